/* rtl/eia_defines.svh */
// Register offsets, field positions, reset values and counts of the indirect memory access
`ifndef EIA_DEFINES_SVH
`define EIA_DEFINES_SVH
`define EIA_AW_FRAME 15
`define EIA_REG_WADDR 15'h0030
`define EIA_REG_WDATA 15'h0031
`define EIA_REG_PADDR 15'h0032
`define EIA_REG_PDATA 15'h0033
`define EIA_REG_STATUS 15'h0034
`define EIA_ST_DONE 0
`define EIA_ST_BUSY 1
`define EIA_DONE_RESET 1'b1
`define EIA_FRAME_BITS 6'd32
`define EIA_CMD_BITS 6'd16
`define EIA_PAGE_WORDS 8
`define EIA_LIN_BASE 9'h074
`define EIA_LIN_COUNT 4'hc
`define EIA_PROG_CYCLES 64
`define EIA_HALF_DIV 4
`define EIA_H_CMD 3'h0
`define EIA_H_RX 3'h1
`define EIA_H_STAT 3'h2
`define EIA_H_INT_ST 3'h3
`define EIA_H_INT_MASK 3'h4
`endif

/* rtl/eia_pkg.sv */
// State types for the two ends of the indirect memory access link, one type per end
package eia_pkg;
  typedef enum logic [1:0] {
    PROG_IDLE = 2'b00,
    PROG_SINGLE = 2'b01,
    PROG_PAGE = 2'b10
  } eia_prog_t;
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_SHIFT = 2'b01,
    HOST_GAP = 2'b10
  } eia_hstate_t;
endpackage : eia_pkg

/* rtl/eia_spi_if.sv */
// Four-wire serial link between controller and device
`timescale 1ns/1ps
interface eia_spi_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  // Undriven return line reads high
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
  modport host (output sck, output cs_n, output mosi, input miso_line);
endinterface : eia_spi_if

/* rtl/eia_device.sv */
// Device end: serial register slave with word and page programming of the array
`timescale 1ns/1ps
`include "eia_defines.svh"
module eia_device #(
  parameter int NVM_WORDS = 512,
  parameter int PROG_CYCLES = `EIA_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  eia_spi_if.dev spi,
  input wire logic [3:0] lin_sel,
  output logic [15:0] lin_entry,
  output logic write_done,
  output logic prog_busy
);
  localparam int AW = $clog2(NVM_WORDS);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int PW = $clog2(`EIA_PAGE_WORDS);

  logic sck_q;
  logic rise;
  logic fall;
  logic [5:0] bit_cnt_q;
  logic [31:0] rx_q;
  logic [31:0] rx_d;
  logic [15:0] tx_q;
  logic miso_q;
  logic [15:0] rd_val;
  logic wr_evt;
  logic [14:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] wa_q;
  logic [15:0] pa_q;
  logic page_mode_q;
  logic [15:0] stage_q [`EIA_PAGE_WORDS];
  logic [`EIA_PAGE_WORDS-1:0] valid_q;
  logic [PW-1:0] page_idx;
  logic [AW-1:0] lin_addr;
  eia_pkg::eia_prog_t state_q;
  logic [CW-1:0] cnt_q;
  logic [15:0] prog_addr_q;
  logic [15:0] prog_data_q;
  logic start;
  logic finish;
  logic done_q;
  logic [15:0] nvm [NVM_WORDS];

  // Edge detection on the serial clock
  assign rise = spi.sck & ~sck_q;
  assign fall = ~spi.sck & sck_q;
  assign rx_d = {rx_q[30:0], spi.mosi};
  assign wr_evt = rise && !spi.cs_n && bit_cnt_q == 6'd31 && !rx_d[31];
  assign wr_addr = rx_d[30:16];
  assign wr_data = rx_d[15:0];

  // Word slot inside the current page
  assign page_idx = pa_q[PW-1:0];

  // Array index of the selected linearization entry
  assign lin_addr = AW'(`EIA_LIN_BASE + {5'h00, lin_sel});

  // Serial frame: read flag, 15-bit address, 16 data bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_q <= 1'b0;
      bit_cnt_q <= 6'h00;
      rx_q <= 32'h0000_0000;
      tx_q <= 16'h0000;
    end else begin
      sck_q <= spi.sck;
      if (spi.cs_n) begin
        bit_cnt_q <= 6'h00;
      end else if (rise) begin
        rx_q <= rx_d;
        bit_cnt_q <= bit_cnt_q + 6'h01;
        if (bit_cnt_q == 6'd15 && rx_d[15]) begin
          tx_q <= rd_val;
        end
      end
    end
  end

  // Read data leaves on falling edges, MSB first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      miso_q <= 1'b0;
    end else if (fall && !spi.cs_n && bit_cnt_q >= `EIA_CMD_BITS) begin
      miso_q <= tx_q[4'hf - bit_cnt_q[3:0]];
    end
  end

  assign spi.miso = miso_q;
  assign spi.miso_oe = ~spi.cs_n;

  // Register read mux; write-only registers read as zero
  always_comb begin
    unique case (rx_d[14:0])
      `EIA_REG_WADDR: rd_val = wa_q;
      `EIA_REG_WDATA: rd_val = nvm[wa_q[AW-1:0]];
      `EIA_REG_STATUS: rd_val = {14'h0000, state_q != eia_pkg::PROG_IDLE, done_q};
      default: rd_val = 16'h0000;
    endcase
  end

  // Word address register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wa_q <= 16'h0000;
    end else if (wr_evt && wr_addr == `EIA_REG_WADDR) begin
      wa_q <= wr_data;
    end
  end

  // Page address and volatile staging buffer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pa_q <= 16'h0000;
      page_mode_q <= 1'b0;
      valid_q <= '0;
    end else if (finish) begin
      page_mode_q <= 1'b0;
      valid_q <= '0;
    end else if (wr_evt && state_q == eia_pkg::PROG_IDLE) begin
      if (wr_addr == `EIA_REG_PADDR) begin
        pa_q <= wr_data;
        page_mode_q <= 1'b1;
      end else if (wr_addr == `EIA_REG_PDATA || (start && page_mode_q)) begin
        stage_q[page_idx] <= wr_data;
        valid_q[page_idx] <= 1'b1;
      end
    end
  end

  // Programming sequencer
  assign start = wr_evt && wr_addr == `EIA_REG_WDATA && state_q == eia_pkg::PROG_IDLE;
  assign finish = state_q != eia_pkg::PROG_IDLE && cnt_q == CW'(1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= eia_pkg::PROG_IDLE;
      cnt_q <= '0;
      prog_addr_q <= 16'h0000;
      prog_data_q <= 16'h0000;
    end else if (start) begin
      cnt_q <= CW'(PROG_CYCLES);
      if (page_mode_q) begin
        state_q <= eia_pkg::PROG_PAGE;
        prog_addr_q <= pa_q;
      end else begin
        state_q <= eia_pkg::PROG_SINGLE;
        prog_addr_q <= wa_q;
        prog_data_q <= wr_data;
      end
    end else if (finish) begin
      state_q <= eia_pkg::PROG_IDLE;
      cnt_q <= '0;
    end else if (state_q != eia_pkg::PROG_IDLE) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  // Done flag: cleared at start, set at finish
  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_q <= `EIA_DONE_RESET;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (start) begin
      done_q <= 1'b0;
    end
  end

  assign write_done = done_q;
  assign prog_busy = state_q != eia_pkg::PROG_IDLE;

  // Array commit; a page lands in one cycle at its aligned base
  always_ff @(posedge clk) begin
    if (finish && state_q == eia_pkg::PROG_SINGLE) begin
      nvm[prog_addr_q[AW-1:0]] <= prog_data_q;
    end
    for (int i = 0; i < `EIA_PAGE_WORDS; i++) begin
      if (finish && state_q == eia_pkg::PROG_PAGE && valid_q[i]) begin
        nvm[{prog_addr_q[AW-1:PW], PW'(i)}] <= stage_q[i];
      end
    end
  end

  // Negative linearization entries for the coordinate rotation unit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lin_entry <= 16'h0000;
    end else if (lin_sel < `EIA_LIN_COUNT) begin
      lin_entry <= nvm[lin_addr];
    end else begin
      lin_entry <= 16'h0000;
    end
  end
endmodule : eia_device

/* rtl/eia_host.sv */
// Controller end: runs serial frames for software and polls programming completion
`timescale 1ns/1ps
`include "eia_defines.svh"
module eia_host #(
  parameter int HALF_DIV = `EIA_HALF_DIV
) (
  input wire logic clk,
  input wire logic nrst,
  eia_spi_if.host spi,
  input wire logic [2:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);
  localparam int DW = $clog2(HALF_DIV + 1);

  eia_pkg::eia_hstate_t state_q;
  logic [DW-1:0] div_q;
  logic tick;
  logic [5:0] rises_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic sck_q;
  logic cs_n_q;
  logic poll_q;
  logic need_poll_q;
  logic pg_last_q;
  logic [15:0] res_q;
  logic int_st_q;
  logic int_mask_q;
  logic cmd;
  logic [31:0] frame;
  logic done_evt;

  assign cmd = wr && addr == `EIA_H_CMD && state_q == eia_pkg::HOST_IDLE;
  assign tick = div_q == DW'(HALF_DIV - 1);
  assign done_evt = state_q == eia_pkg::HOST_GAP && tick && !(need_poll_q && !(poll_q && rx_q[0]));

  // Last word of a page goes to the word data register
  always_comb begin
    frame = wdata;
    if (!wdata[31] && wdata[30:16] == `EIA_REG_PDATA && pg_last_q) begin
      frame[30:16] = `EIA_REG_WDATA;
    end
  end

  // Track whether the page address written last closes its page
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pg_last_q <= 1'b0;
    end else if (cmd && !wdata[31] && wdata[30:16] == `EIA_REG_PADDR) begin
      pg_last_q <= wdata[2:0] == 3'h7;
    end
  end

  // Frame engine: mode 0, data out on falling edge, sampled on rising
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= eia_pkg::HOST_IDLE;
      div_q <= '0;
      rises_q <= 6'h00;
      tx_q <= 32'h0000_0000;
      rx_q <= 32'h0000_0000;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      poll_q <= 1'b0;
      need_poll_q <= 1'b0;
    end else begin
      div_q <= (state_q == eia_pkg::HOST_IDLE || tick) ? '0 : div_q + DW'(1);
      unique case (state_q)
        eia_pkg::HOST_IDLE: begin
          if (cmd) begin
            tx_q <= frame;
            need_poll_q <= !frame[31] && frame[30:16] == `EIA_REG_WDATA;
            poll_q <= 1'b0;
            cs_n_q <= 1'b0;
            rises_q <= 6'h00;
            state_q <= eia_pkg::HOST_SHIFT;
          end
        end
        eia_pkg::HOST_SHIFT: begin
          if (tick) begin
            sck_q <= ~sck_q;
            if (!sck_q) begin
              rx_q <= {rx_q[30:0], spi.miso_line};
              rises_q <= rises_q + 6'h01;
            end else if (rises_q == `EIA_FRAME_BITS) begin
              cs_n_q <= 1'b1;
              state_q <= eia_pkg::HOST_GAP;
            end else begin
              tx_q <= {tx_q[30:0], 1'b0};
            end
          end
        end
        eia_pkg::HOST_GAP: begin
          if (tick && need_poll_q && !(poll_q && rx_q[0])) begin
            tx_q <= {1'b1, `EIA_REG_STATUS, 16'h0000};
            poll_q <= 1'b1;
            cs_n_q <= 1'b0;
            rises_q <= 6'h00;
            state_q <= eia_pkg::HOST_SHIFT;
          end else if (tick) begin
            need_poll_q <= 1'b0;
            state_q <= eia_pkg::HOST_IDLE;
          end
        end
        default: state_q <= eia_pkg::HOST_IDLE;
      endcase
    end
  end

  assign spi.sck = sck_q;
  assign spi.cs_n = cs_n_q;
  assign spi.mosi = tx_q[31];

  // Result word of the finished transfer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      res_q <= 16'h0000;
    end else if (done_evt) begin
      res_q <= rx_q[15:0];
    end
  end

  // Sticky completion event; set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      int_st_q <= 1'b0;
      int_mask_q <= 1'b0;
    end else begin
      int_st_q <= (int_st_q & ~(wr && addr == `EIA_H_INT_ST && wdata[0])) | done_evt;
      if (wr && addr == `EIA_H_INT_MASK) begin
        int_mask_q <= wdata[0];
      end
    end
  end

  assign irq = int_st_q & int_mask_q;

  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        `EIA_H_RX: rdata <= {16'h0000, res_q};
        `EIA_H_STAT: rdata <= {31'h0000_0000, state_q != eia_pkg::HOST_IDLE};
        `EIA_H_INT_ST: rdata <= {31'h0000_0000, int_st_q};
        `EIA_H_INT_MASK: rdata <= {31'h0000_0000, int_mask_q};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule : eia_host

/* verification/eia_link_asserts.sv */
// Timing checks on the serial link between controller and device
`timescale 1ns/1ps
module eia_link_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  logic sck_q;
  logic [5:0] rises_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Rising serial clock edges within one frame
  always_ff @(posedge clk) begin
    sck_q <= sck;
    if (!nrst || cs_n) begin
      rises_q <= 6'h00;
    end else if (sck && !sck_q) begin
      rises_q <= rises_q + 6'h01;
    end
  end
  AST_RST_IDLE: assert property ($rose(nrst) |-> cs_n && !sck)
    else $error("link not idle after reset");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("serial clock moves outside a frame");
  AST_OE_SEL: assert property (cs_n |-> !miso_oe && miso_line)
    else $error("return line driven while deselected");
  AST_SCK_HIGH: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("serial clock high phase wrong");
  AST_SCK_LOW: assert property ($fell(sck) |-> !sck[*4])
    else $error("serial clock low phase too short");
  AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data moved while clock high");
  AST_MISO_HOLD: assert property (sck && $past(sck) |-> $stable(miso))
    else $error("device data moved while clock high");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> rises_q == 6'd32)
    else $error("frame not 32 clock edges long");
endmodule : eia_link_asserts

/* verification/testbench.sv */
// Self-checking bench joining controller and device over the serial link
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] lin_sel = 4'h0;
  logic [31:0] rdata;
  logic [15:0] lin_entry;
  logic irq;
  logic write_done;
  logic prog_busy;
  logic busy_q;
  logic [31:0] got;
  int fails = 0;
  int samples_checked = 0;
  int starts = 0;
  int stale = 0;
  int cycles = 0;
  eia_spi_if u_eia_spi_if ();
  eia_device u_eia_device (.clk(clk), .nrst(nrst), .spi(u_eia_spi_if), .lin_sel(lin_sel),
    .lin_entry(lin_entry), .write_done(write_done), .prog_busy(prog_busy));
  eia_host u_eia_host (.clk(clk), .nrst(nrst), .spi(u_eia_spi_if), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  eia_link_asserts u_eia_link_asserts (.clk(clk), .nrst(nrst), .sck(u_eia_spi_if.sck),
    .cs_n(u_eia_spi_if.cs_n), .mosi(u_eia_spi_if.mosi), .miso(u_eia_spi_if.miso),
    .miso_oe(u_eia_spi_if.miso_oe), .miso_line(u_eia_spi_if.miso_line));
  // Clock
  initial begin
    forever #5 clk = ~clk;
  end
  // Programming starts, stale done flag and run ceiling
  always @(posedge clk) begin
    busy_q <= prog_busy;
    if (prog_busy === 1'b1 && busy_q === 1'b0) starts <= starts + 1;
    if (prog_busy === 1'b1 && busy_q === 1'b1 && write_done !== 1'b0) stale <= stale + 1;
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fails = fails + 1;
      results();
    end
  end
  function automatic logic [15:0] ev(input int i);
    return 16'hc3a0 + 16'(i);
  endfunction : ev
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wreg(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rreg
  // Start one transfer and poll its completion flag
  task automatic send(input logic rdn, input logic [14:0] ra, input logic [15:0] d);
    wreg(3'h0, {rdn, ra, d});
    rreg(3'h2);
    chk(got, 32'h1);
    got = 32'h0;
    for (int i = 0; i < 1000 && got[0] !== 1'b1; i++) rreg(3'h3);
    chk({31'h0, got[0]}, 32'h1);
    rreg(3'h2);
    chk(got, 32'h0);
  endtask : send
  task automatic xfer(input logic rdn, input logic [14:0] ra, input logic [15:0] d);
    send(rdn, ra, d);
    wreg(3'h3, 32'h1);
  endtask : xfer
  // Reset values and an unmapped index
  task automatic t_reset();
    chk({31'h0, write_done}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rreg(3'h7);
    chk(got, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  // Masked, unmasked and cleared completion interrupt
  task automatic t_irq();
    wreg(3'h4, 32'h0);
    send(1'b1, 15'h0030, 16'h0);
    chk({31'h0, irq}, 32'h0);
    wreg(3'h4, 32'h1);
    rreg(3'h4);
    chk(got, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wreg(3'h3, 32'h1);
    rreg(3'h3);
    chk({31'h0, irq}, 32'h0);
    chk(got, 32'h0);
    wreg(3'h4, 32'h0);
    $display("t_irq done");
  endtask : t_irq
  // Single word program and read back
  task automatic t_single();
    int s;
    for (int i = 0; i < 4; i++) begin
      s = starts;
      xfer(1'b0, 15'h0030, 16'h0074 + 16'(i));
      xfer(1'b0, 15'h0031, ev(i));
      chk(32'(starts - s), 32'h1);
      chk({31'h0, write_done}, 32'h1);
      xfer(1'b1, 15'h0031, 16'h0);
      rreg(3'h1);
      chk({16'h0, got[15:0]}, {16'h0, ev(i)});
    end
    $display("t_single done");
  endtask : t_single
  // Page program staged through page registers, eighth word written to word data, committed once
  task automatic t_page();
    int s;
    s = starts;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, 15'h0032, 16'h0078 + 16'(i));
      xfer(1'b0, 15'h0033, ev(i + 4));
    end
    chk(32'(starts - s), 32'h0);
    xfer(1'b0, 15'h0032, 16'h007f);
    xfer(1'b0, 15'h0031, ev(11));
    chk(32'(starts - s), 32'h1);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 15'h0030, 16'h0078 + 16'(i));
      xfer(1'b1, 15'h0031, 16'h0);
      rreg(3'h1);
      chk({16'h0, got[15:0]}, {16'h0, ev(i + 4)});
    end
    $display("t_page done");
  endtask : t_page
  // Eighth page word sent to page data, steered to word data by the controller
  task automatic t_steer();
    int s;
    s = starts;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, 15'h0032, 16'h0008 + 16'(i));
      xfer(1'b0, 15'h0033, 16'h5a00 + 16'(i));
    end
    chk(32'(starts - s), 32'h0);
    xfer(1'b0, 15'h0032, 16'h000f);
    xfer(1'b0, 15'h0033, 16'h5a07);
    chk(32'(starts - s), 32'h1);
    chk({31'h0, write_done}, 32'h1);
    for (int i = 0; i < 8; i += 7) begin
      xfer(1'b0, 15'h0030, 16'h0008 + 16'(i));
      xfer(1'b1, 15'h0031, 16'h0);
      rreg(3'h1);
      chk({16'h0, got[15:0]}, {16'h0, 16'h5a00 + 16'(i)});
    end
    $display("t_steer done");
  endtask : t_steer
  // Command refused while a transfer runs; word address keeps its value
  task automatic t_busy();
    wreg(3'h0, {1'b1, 15'h0030, 16'h0000});
    xfer(1'b0, 15'h0030, 16'h0123);
    rreg(3'h1);
    chk(got, 32'h0000_000f);
    xfer(1'b1, 15'h0030, 16'h0000);
    rreg(3'h1);
    chk(got, 32'h0000_000f);
    $display("t_busy done");
  endtask : t_busy
  // Linearization entries from the array
  task automatic t_lin();
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      lin_sel <= 4'(i);
      repeat (3) @(posedge clk);
      #1 chk({16'h0, lin_entry}, i < 12 ? {16'h0, ev(i)} : 32'h0);
    end
    $display("t_lin done");
  endtask : t_lin
  task automatic results();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_irq();
    t_single();
    t_page();
    t_steer();
    t_busy();
    t_lin();
    chk(32'(stale), 32'h0);
    results();
  end
endmodule : testbench
